// ### bench/adc_conversion_control_bench.sv
// self-checking bench: host model on the bus, comparator model on the analog side
module adc_conversion_control_bench
  import adc_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        ce = 1'b1;
  logic        uni = 1'b1;
  logic        dac_en = 1'b0;
  logic        flt = 1'b0;
  logic [10:0] base = 11'h000;
  logic [11:0] ain = 12'h000;
  logic [11:0] last = RESULT_RST;
  logic [2:0]  cur_ch = CHAN_RST;
  isa_bus_t    bus;
  logic [7:0]  sd_out;
  logic        sd_oe;
  logic [2:0]  mux_sel;
  logic [11:0] trial;
  logic        st_n;
  logic        lo_n;
  logic        hi_n;
  logic        busy;
  int          err_total = 0;
  int          n_tests = 0;
  int          seed = 32'hed01;
  logic [11:0] corner_a [6] = '{12'h000, 12'hfff, 12'h000, 12'h800, 12'hfff, 12'h7ff};
  logic [5:0]  corner_u = 6'h03;

  always #2.5 clk = ~clk;

  // ideal comparator; ain is the input as an offset-binary code
  wire cmp = (ain >= trial);

  adc_conversion_control #(.BIT_CYCLES(8)) uut (
    .clk(clk), .rstn(rstn), .ce(ce), .isa_in(bus), .base_addr(base), .uni_strap(uni),
    .cmp_in(cmp), .dac_enabled(dac_en), .fault(flt), .sd_out(sd_out), .sd_oe(sd_oe),
    .mux_sel(mux_sel), .sar_trial(trial), .conv_start_strobe_n(st_n),
    .result_low_read_strobe_n(lo_n), .result_high_read_strobe_n(hi_n),
    .conv_busy_flag(busy));

  isa_host_model host (.clk(clk), .sd_out(sd_out), .sd_oe(sd_oe),
    .strb({st_n, lo_n, hi_n}), .bus(bus));

  // bipolar codes are the offset-binary code with the top bit flipped
  function automatic logic [11:0] expect_code(input logic [11:0] a, input logic u);
    return u ? a : {~a[11], a[10:0]};
  endfunction : expect_code

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // select, start, poll, fetch; the old result is read while busy to see it held
  task automatic convert(input logic [2:0] ch, input logic [11:0] a, input logic u);
    int          n;
    logic [11:0] e;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [11:0] t;
    e = expect_code(a, u);
    @(posedge clk);
    uni    <= u;
    ain    <= a;
    dac_en <= 1'($random(seed));
    flt    <= 1'($random(seed));
    cur_ch = ch;
    host.select(base, {5'h00, ch});
    chk(mux_sel, ch, "channel");
    host.cyc(1'b1, {base, OFS_START}, 8'($random(seed)), 1'b0);
    chk(host.st_q[2], 1'b0, "start strobe");
    chk(busy, 1'b1, "busy set");
    host.cyc(1'b0, {base, OFS_STATUS}, 8'h00, 1'b0);
    chk(host.rd_q, {4'h0, u, dac_en, 1'b1, flt}, "status");
    host.cyc(1'b0, {base, OFS_LOW}, 8'h00, 1'b0);
    chk(host.rd_q, last[7:0], "held low");
    // freeze mid conversion: the trial code and busy must not move while ce is low
    ce <= 1'b0;
    @(posedge clk);
    #1;
    t = trial;
    repeat (10) @(posedge clk);
    #1;
    chk(trial, t, "frozen trial");
    chk(busy, 1'b1, "frozen busy");
    @(posedge clk);
    ce <= 1'b1;
    n = 0;
    while (busy === 1'b1 && n < CONV_MAX_CYCLES) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(busy, 1'b0, "busy cleared");
    host.fetch(base, lo, hi);
    chk(host.lo_st, 1'b0, "low strobe");
    chk(host.hi_st, 1'b0, "high strobe");
    chk(lo, e[7:0], "low byte");
    chk(hi, {4'h0, e[11:8]}, "high nibble");
    last = e;
    $display("test done: ch %0d uni %0d code %h", ch, u, e);
  endtask : convert

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    base <= 11'($random(seed));
    repeat (4) @(posedge clk);
    for (int i = 0; i < 6; i++) convert(3'(i), corner_a[i], corner_u[i]);
    for (int i = 0; i < 6; i++) convert(3'($random(seed)), 12'($random(seed)), 1'($random(seed)));
    // foreign base, dma cycles and enable-mode writes must leave the card alone
    host.cyc(1'b0, {base ^ 11'h001, OFS_STATUS}, 8'h00, 1'b0);
    chk(host.rd_oe, 1'b0, "foreign base");
    host.cyc(1'b0, {base, OFS_STATUS}, 8'h00, 1'b1);
    chk(host.rd_oe, 1'b0, "dma read");
    host.cyc(1'b1, {base, OFS_START}, 8'h00, 1'b1);
    chk(busy, 1'b0, "dma start");
    host.cyc(1'b1, {base, OFS_CHANNEL_CONTROL_PORT}, 8'h0d, 1'b0);
    chk(mux_sel, cur_ch, "enable write");
    $display("test done: refusals");
    // reset in mid conversion after a channel change, then convert from the reset state
    host.cyc(1'b1, {base, OFS_START}, 8'h00, 1'b0);
    host.cyc(1'b1, {base, OFS_CHANNEL_CONTROL_PORT}, 8'h07, 1'b0);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(mux_sel, CHAN_RST, "reset channel");
    chk(busy, 1'b0, "reset busy");
    @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    last = RESULT_RST;
    convert(3'h6, 12'h9c4, 1'b1);
    report_and_stop;
  end

  // watchdog sized well above thirteen conversions with settling
  initial begin
    #400000;
    err_total++;
    report_and_stop;
  end
endmodule : adc_conversion_control_bench

// ### bench/isa_host_model.sv
// host model: drives isa pins for i/o cycles and keeps the host-side spacing
module isa_host_model
  import adc_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] sd_out,
  input  wire logic       sd_oe,
  input  wire logic [2:0] strb,
  output isa_bus_t        bus
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] rd_q;
  logic       rd_oe;
  logic [2:0] st_q;
  logic       lo_st;
  logic       hi_st;

  // idle pins: strobes high, data lines start at the 5a filler pattern
  initial bus = '{addr: 16'h0000, aen: 1'b0, iow_n: 1'b1, ior_n: 1'b1, data: 8'h5a};

  // strobe low 6 cycles then high at least 6, above the 4 the card needs for clean sync
  task automatic cyc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                     input logic aen);
    @(posedge clk);
    bus.addr  <= a;
    bus.aen   <= aen;
    bus.data  <= wr ? d : ~bus.data;  // released lines never echo the last value
    bus.iow_n <= ~wr;
    bus.ior_n <= wr;
    repeat (5) @(posedge clk);
    #1;
    rd_q  = sd_out;
    rd_oe = sd_oe;
    st_q  = strb;
    @(posedge clk);
    bus.iow_n <= 1'b1;
    bus.ior_n <= 1'b1;
    bus.data  <= ~bus.data;
    repeat (5) @(posedge clk);
  endtask : cyc

  // channel change followed by settling before any start
  task automatic select(input logic [10:0] b, input logic [7:0] d);
    cyc(1'b1, {b, OFS_CHANNEL_CONTROL_PORT}, d, 1'b0);
    repeat (SETTLE_TIME_NS / CLK_PERIOD_NS) @(posedge clk);
  endtask : select

  // low byte first, then high nibble, once each with the minimum gap
  task automatic fetch(input logic [10:0] b, output logic [7:0] lo, output logic [7:0] hi);
    cyc(1'b0, {b, OFS_LOW}, 8'h00, 1'b0);
    lo    = rd_q;
    lo_st = st_q[1];
    repeat (READ_GAP_NS / CLK_PERIOD_NS) @(posedge clk);
    cyc(1'b0, {b, OFS_HIGH}, 8'h00, 1'b0);
    hi    = rd_q;
    hi_st = st_q[0];
  endtask : fetch
endmodule : isa_host_model

// ### core/adc_conversion_control.sv
// isa i/o slave front end, channel select, start, status and result ports
module adc_conversion_control
  import adc_ctrl_pkg::*;
#(
  parameter int BIT_CYCLES = SAR_BIT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire isa_bus_t    isa_in,
  input  wire logic [10:0] base_addr,
  input  wire logic        uni_strap,
  input  wire logic        cmp_in,
  input  wire logic        dac_enabled,
  input  wire logic        fault,
  output logic      [7:0]  sd_out,
  output logic             sd_oe,
  output logic      [2:0]  mux_sel,
  output logic      [11:0] sar_trial,
  output logic             conv_start_strobe_n,
  output logic             result_low_read_strobe_n,
  output logic             result_high_read_strobe_n,
  output logic             conv_busy_flag
);

  pin_in_t     raw_w;
  pin_in_t     pin_s;
  isa_bus_t    bus_s;
  logic        sel_w;
  logic [4:0]  ofs_w;
  logic        wr_lvl_w;
  logic        rd_lvl_w;
  logic        iow_n_q;
  logic        wr_edge_w;
  logic        start_w;
  logic        rd_map_w;
  logic [7:0]  rd_data_w;
  logic [7:0]  status_w;
  logic [11:0] code_w;
  logic        done_w;
  logic        mode_uni_r;
  logic [11:0] result_r;
  logic [4:0]  sd_ofs_r;

  // bus pins, base, strap and comparator cross two flops before any decode looks at them; dac_enabled and fault do not
  assign raw_w.bus.addr  = isa_in.addr;
  assign raw_w.bus.aen   = isa_in.aen;
  assign raw_w.bus.iow_n = !isa_in.iow_n;  // crosses inverted: all-zero reset means idle
  assign raw_w.bus.ior_n = !isa_in.ior_n;
  assign raw_w.bus.data  = isa_in.data;
  assign raw_w.base      = base_addr;
  assign raw_w.uni_strap = uni_strap;
  assign raw_w.cmp       = cmp_in;

  pin_sync #(
    .W ($bits(pin_in_t))
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .d    (raw_w),
    .q    (pin_s)
  );

  // strobes are active low again on this side; straight after reset they read idle,
  // so the write edge detector cannot see a false falling edge
  assign bus_s.addr  = pin_s.bus.addr;
  assign bus_s.aen   = pin_s.bus.aen;
  assign bus_s.iow_n = !pin_s.bus.iow_n;
  assign bus_s.ior_n = !pin_s.bus.ior_n;
  assign bus_s.data  = pin_s.bus.data;

  // full 16-bit decode, dma cycles (aen high) never select the card
  assign sel_w    = !bus_s.aen && (bus_s.addr[15:5] == pin_s.base);
  assign ofs_w    = bus_s.addr[4:0];
  assign wr_lvl_w = sel_w && !bus_s.iow_n;
  assign rd_lvl_w = sel_w && !bus_s.ior_n;

  // strobes follow the host strobes as levels, gated by the port address
  assign conv_start_strobe_n       = !(wr_lvl_w && ofs_w == OFS_START);
  assign result_low_read_strobe_n  = !(rd_lvl_w && ofs_w == OFS_LOW);
  assign result_high_read_strobe_n = !(rd_lvl_w && ofs_w == OFS_HIGH);

  // one action per write: act on the falling edge of the write strobe only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      iow_n_q <= 1'b1;
    end else if (ce) begin
      iow_n_q <= bus_s.iow_n;
    end
  end

  assign wr_edge_w = iow_n_q && !bus_s.iow_n && sel_w;
  assign start_w   = wr_edge_w && ofs_w == OFS_START;

  // channel select; mode bit set means the write targets enables held elsewhere
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mux_sel <= CHAN_RST;
    end else if (ce) begin
      if (wr_edge_w && ofs_w == OFS_CHANNEL_CONTROL_PORT && !bus_s.data[BIT_CH_MODE]) begin
        mux_sel <= bus_s.data[2:0];
      end
    end
  end

  sar_engine #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_sar (
    .clk   (clk),
    .rstn  (rstn),
    .ce    (ce),
    .start (start_w),
    .cmp   (pin_s.cmp),
    .trial (sar_trial),
    .code  (code_w),
    .done  (done_w),
    .busy  (conv_busy_flag)
  );

  // format is latched at start so a strap change cannot split one result
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_uni_r <= 1'b1;
    end else if (ce) begin
      if (start_w) begin
        mode_uni_r <= pin_s.uni_strap;
      end
    end
  end

  // result changes only when a conversion completes; bipolar flips the offset-binary msb
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_r <= RESULT_RST;
    end else if (ce) begin
      if (done_w) begin
        if (mode_uni_r) begin
          result_r <= code_w;
        end else begin
          result_r <= {~code_w[11], code_w[10:0]};
        end
      end
    end
  end

  // status byte, upper nibble reads zero
  assign status_w = {4'h0, pin_s.uni_strap, dac_enabled, conv_busy_flag, fault};

  // read mux; unlisted offsets belong to other functions and are not driven
  always_comb begin
    rd_map_w  = 1'b1;
    rd_data_w = DATA_RST;
    case (ofs_w)
      OFS_STATUS: rd_data_w = status_w;
      OFS_LOW:    rd_data_w = result_r[7:0];
      OFS_HIGH:   rd_data_w = {4'h0, result_r[11:8]};
      default:    rd_map_w  = 1'b0;
    endcase
  end

  // enable is registered so the bus sees it change together with the data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sd_oe <= 1'b0;
    end else if (ce) begin
      sd_oe <= rd_lvl_w && rd_map_w;
    end
  end

  // offset behind the registered data, so the checks know which port was read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sd_ofs_r <= 5'h00;
    end else if (ce) begin
      sd_ofs_r <= ofs_w;
    end
  end

  // data loads only during a decoded read and holds otherwise, which saves
  // toggling the bus drivers while the card is not addressed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sd_out <= DATA_RST;
    end else if (ce) begin
      if (rd_lvl_w && rd_map_w) begin
        sd_out <= rd_data_w;
      end
    end
  end

  // helper: cycles spent busy since the last start
  logic [15:0] busy_cnt_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_cnt_r <= 16'h0000;
    end else if (ce) begin
      if (start_w) begin
        busy_cnt_r <= 16'h0000;
      end else if (conv_busy_flag) begin
        busy_cnt_r <= busy_cnt_r + 16'h0001;
      end
    end
  end

  chk_conv_time_bound: assert property (@(posedge clk) disable iff (!rstn)
    busy_cnt_r < 16'(CONV_MAX_CYCLES)) else $error("conversion exceeded time limit");

  chk_start_sets_busy: assert property (@(posedge clk) disable iff (!rstn)
    start_w && ce |=> conv_busy_flag) else $error("start did not set busy");

  chk_start_strobe_coincide: assert property (@(posedge clk) disable iff (!rstn)
    !conv_start_strobe_n |-> !bus_s.iow_n && sel_w && ofs_w == OFS_START)
    else $error("start strobe without host write");

  chk_low_read_strobe: assert property (@(posedge clk) disable iff (!rstn)
    (!bus_s.ior_n && sel_w && ofs_w == OFS_LOW) |-> !result_low_read_strobe_n)
    else $error("low read strobe missing");

  chk_high_read_strobe: assert property (@(posedge clk) disable iff (!rstn)
    (!bus_s.ior_n && sel_w && ofs_w == OFS_HIGH) |-> !result_high_read_strobe_n)
    else $error("high read strobe missing");

  chk_high_nibble_zero: assert property (@(posedge clk) disable iff (!rstn)
    sd_oe && sd_ofs_r == OFS_HIGH |-> sd_out[7:4] == 4'h0)
    else $error("high result upper bits not zero");

  chk_bipolar_format: assert property (@(posedge clk) disable iff (!rstn)
    done_w && ce && !mode_uni_r |=> result_r == {~$past(code_w[11]), $past(code_w[10:0])})
    else $error("bipolar result not two's complement");

  chk_unipolar_format: assert property (@(posedge clk) disable iff (!rstn)
    done_w && ce && mode_uni_r |=> result_r == $past(code_w))
    else $error("unipolar result not straight binary");

  chk_result_held: assert property (@(posedge clk) disable iff (!rstn)
    !done_w |=> $stable(result_r)) else $error("result changed without completion");

  chk_decode_only: assert property (@(posedge clk) disable iff (!rstn)
    $rose(sd_oe) |-> $past(sel_w) && !$past(bus_s.ior_n))
    else $error("bus driven without decoded read");

  chk_channel_route: assert property (@(posedge clk) disable iff (!rstn)
    wr_edge_w && ce && ofs_w == OFS_CHANNEL_CONTROL_PORT && !bus_s.data[BIT_CH_MODE]
    |=> mux_sel == $past(bus_s.data[2:0])) else $error("channel not routed");

  chk_busy_status: assert property (@(posedge clk) disable iff (!rstn)
    sd_oe && sd_ofs_r == OFS_STATUS && $past(ce) && $past(rd_lvl_w)
    |-> sd_out[BIT_BUSY] == $past(conv_busy_flag)) else $error("status busy bit wrong");

  // checks that look one edge back also want ce high there, since a frozen
  // edge leaves the registers showing older values than the sampled inputs
  chk_oe_needs_read: assert property (@(posedge clk) disable iff (!rstn)
    sd_oe && $past(ce) |-> $past(rd_lvl_w) && $past(rd_map_w))
    else $error("data driven without a decoded read");

  chk_refused_quiet: assert property (@(posedge clk) disable iff (!rstn)
    !sel_w && ce |=> !sd_oe) else $error("data driven for a foreign address");

  chk_low_byte_value: assert property (@(posedge clk) disable iff (!rstn)
    sd_oe && sd_ofs_r == OFS_LOW && $past(ce) |-> sd_out == $past(result_r[7:0]))
    else $error("low result byte wrong");

  chk_high_nibble_value: assert property (@(posedge clk) disable iff (!rstn)
    sd_oe && sd_ofs_r == OFS_HIGH && $past(ce) |-> sd_out[3:0] == $past(result_r[11:8]))
    else $error("high result nibble wrong");

  chk_status_upper_zero: assert property (@(posedge clk) disable iff (!rstn)
    sd_oe && sd_ofs_r == OFS_STATUS |-> sd_out[7:4] == 4'h0)
    else $error("status upper bits not zero");

  chk_busy_from_start: assert property (@(posedge clk) disable iff (!rstn)
    $rose(conv_busy_flag) |-> $past(start_w)) else $error("busy set without start");

  chk_mode_latch: assert property (@(posedge clk) disable iff (!rstn)
    start_w && ce |=> mode_uni_r == $past(pin_s.uni_strap))
    else $error("format not taken at start");

  chk_mode_held: assert property (@(posedge clk) disable iff (!rstn)
    !start_w |=> $stable(mode_uni_r)) else $error("format changed without start");

  chk_channel_held: assert property (@(posedge clk) disable iff (!rstn)
    !wr_edge_w |=> $stable(mux_sel)) else $error("channel changed without write");

  chk_idle_no_start: assert property (@(posedge clk) disable iff (!rstn)
    bus_s.iow_n |-> conv_start_strobe_n) else $error("start strobe without write");

  chk_idle_no_read: assert property (@(posedge clk) disable iff (!rstn)
    bus_s.ior_n |-> result_low_read_strobe_n && result_high_read_strobe_n)
    else $error("read strobe without host read");

  chk_freeze_state: assert property (@(posedge clk) disable iff (!rstn)
    !ce |=> $stable(conv_busy_flag) && $stable(mux_sel) && $stable(result_r)
    && $stable(sar_trial)) else $error("state moved while clock enable low");

endmodule : adc_conversion_control

// ### core/adc_ctrl_pkg.sv
// package: constants and carrier types for the converter control block
package adc_ctrl_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS   = 5;
  localparam int CONV_TIME_NS    = 10000;
  localparam int CONV_MAX_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;  // longest time: round down
  localparam int READ_GAP_NS     = 1100;                          // host side spacing
  localparam int SETTLE_TIME_NS  = 9000;                          // host side settling
  localparam int SAR_BIT_CYCLES  = (CONV_MAX_CYCLES - 16) / 12;   // margin for sync lag

  // port offsets inside the 32-byte block
  localparam logic [4:0] OFS_STATUS = 5'h0b;
  localparam logic [4:0] OFS_CHANNEL_CONTROL_PORT = 5'h0c;
  localparam logic [4:0] OFS_START  = 5'h0d;
  localparam logic [4:0] OFS_LOW    = 5'h0c;
  localparam logic [4:0] OFS_HIGH   = 5'h0d;

  // field positions
  localparam int BIT_FAULT    = 0;
  localparam int BIT_BUSY     = 1;
  localparam int BIT_DAC_EN   = 2;
  localparam int BIT_UNIPOLAR = 3;
  localparam int BIT_CH_MODE  = 3;

  // reset values
  localparam logic [2:0]  CHAN_RST   = 3'h0;
  localparam logic [11:0] RESULT_RST = 12'h000;
  localparam logic [7:0]  DATA_RST   = 8'h00;

  // isa pins as seen by the card
  typedef struct packed {
    logic [15:0] addr;
    logic        aen;
    logic        iow_n;
    logic        ior_n;
    logic [7:0]  data;
  } isa_bus_t;

  // everything that arrives from outside the clock domain
  typedef struct packed {
    isa_bus_t    bus;
    logic [10:0] base;
    logic        uni_strap;
    logic        cmp;
  } pin_in_t;

  typedef enum logic [1:0] {
    SAR_IDLE  = 2'b01,
    SAR_TRIAL = 2'b10
  } sar_state_t;

endpackage : adc_ctrl_pkg

// ### core/pin_sync.sv
// two-flop synchroniser for a bundle of asynchronous pins
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // first stage is read only by the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : pin_sync

// ### core/sar_engine.sv
// successive-approximation sequencer driving the trial dac and reading the comparator
module sar_engine
  import adc_ctrl_pkg::*;
#(
  parameter int BIT_CYCLES = SAR_BIT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic        cmp,
  output logic      [11:0] trial,
  output logic      [11:0] code,
  output logic             done,
  output logic             busy
);

  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(BIT_CYCLES - 1);

  sar_state_t     state_r;
  logic [CW-1:0]  cnt_r;
  logic [3:0]     bit_r;

  // a start always restarts, even mid conversion; each bit settles for a full window
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= SAR_IDLE;
      cnt_r   <= '0;
      bit_r   <= 4'hb;
      trial   <= 12'h000;
      code    <= RESULT_RST;
      done    <= 1'b0;
      busy    <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        state_r <= SAR_TRIAL;
        cnt_r   <= '0;
        bit_r   <= 4'hb;
        trial   <= 12'h800;
        busy    <= 1'b1;
      end else begin
        case (state_r)
          SAR_IDLE: begin
            cnt_r <= '0;
          end
          SAR_TRIAL: begin
            if (cnt_r == CNT_LAST) begin
              cnt_r <= '0;
              if (!cmp) begin
                trial[bit_r] <= 1'b0;
              end
              if (bit_r == 4'h0) begin
                code    <= {trial[11:1], cmp};
                done    <= 1'b1;
                busy    <= 1'b0;
                state_r <= SAR_IDLE;
              end else begin
                trial[bit_r - 4'h1] <= 1'b1;
                bit_r               <= bit_r - 4'h1;
              end
            end else begin
              cnt_r <= cnt_r + CW'(1);
            end
          end
          default: begin
            state_r <= SAR_IDLE;
          end
        endcase
      end
    end
  end

  chk_done_clears_busy: assert property (@(posedge clk) disable iff (!rstn)
    done |-> !busy) else $error("busy still set after result");

endmodule : sar_engine
